// *** hdl/pucr_pkg.sv ***
// Shared constants and carrier types for the port configuration register bank.
package pucr_pkg;
    // ******************************************************************
    // Register map
    // ******************************************************************
    localparam logic [11:0] PUCR_PP_BANK = 12'h000;
    localparam logic [11:0] PUCR_SER1_BANK = 12'h400;
    localparam logic [7:0] PUCR_PP_MODE_IDX = 8'hF0;
    localparam logic [7:0] PUCR_PP_MODE2_IDX = 8'hF1;
    localparam logic [7:0] PUCR_SER1_MODE_IDX = 8'hF0;
    localparam logic [11:0] PUCR_PP_MODE_ADDR = PUCR_PP_BANK + {2'h0, PUCR_PP_MODE_IDX, 2'h0};
    localparam logic [11:0] PUCR_PP_MODE2_ADDR = PUCR_PP_BANK + {2'h0, PUCR_PP_MODE2_IDX, 2'h0};
    localparam logic [11:0] PUCR_SER1_MODE_ADDR = PUCR_SER1_BANK + {2'h0, PUCR_SER1_MODE_IDX, 2'h0};
    localparam logic [11:0] PUCR_IRQ_STAT_ADDR = 12'h800;
    localparam logic [11:0] PUCR_IRQ_EN_ADDR = 12'h804;
    localparam logic [11:0] PUCR_IRQ_CLR_ADDR = 12'h808;
    // ******************************************************************
    // Reset values and fields
    // ******************************************************************
    localparam logic [7:0] PUCR_PP_MODE_RST = 8'h3C;
    localparam logic [1:0] PUCR_PP_MODE2_RST = 2'h0;
    localparam logic [7:0] PUCR_SER1_MODE_RST = 8'h00;
    localparam logic [7:0] PUCR_SER1_RSVD_MASK = 8'h7C;
    localparam int PUCR_MODE_LSB = 0;
    localparam int PUCR_THR_LSB = 3;
    localparam int PUCR_ITYPE_BIT = 7;
    localparam int PUCR_MIDI_BIT = 0;
    localparam int PUCR_HS_BIT = 1;
    localparam int PUCR_SHARE_BIT = 7;
    localparam int PUCR_EVT_W = 3;
    localparam int PUCR_EVT_PULSE = 0;
    localparam int PUCR_EVT_SHARED = 1;
    localparam int PUCR_EVT_RSVD = 2;
    localparam logic [1:0] PUCR_RESP_OKAY = 2'h0;
    localparam logic [1:0] PUCR_RESP_SLVERR = 2'h2;
    // ******************************************************************
    // Modes
    // ******************************************************************
    localparam logic [2:0] PUCR_PM_PRINTER = 3'h4;
    localparam logic [2:0] PUCR_PM_SPP = 3'h0;
    localparam logic [2:0] PUCR_PM_EPP19 = 3'h1;
    localparam logic [2:0] PUCR_PM_EPP17 = 3'h5;
    localparam logic [2:0] PUCR_PM_ECP = 3'h2;
    localparam logic [2:0] PUCR_PM_ECP_EPP19 = 3'h3;
    localparam logic [2:0] PUCR_PM_ECP_EPP17 = 3'h7;
    localparam logic [2:0] PUCR_ECR_PRINTER = 3'h0;
    localparam logic [2:0] PUCR_ECR_SPP = 3'h1;
    localparam logic [2:0] PUCR_ECR_EPP = 3'h4;
    localparam logic [1:0] PUCR_MUX_NORMAL = 2'h0;
    localparam logic [1:0] PUCR_MUX_DRIVE1 = 2'h1;
    localparam logic [1:0] PUCR_MUX_DRIVES01 = 2'h2;
    // ******************************************************************
    // Timing
    // ******************************************************************
    localparam int PUCR_CLK_KHZ = 40000;
    localparam int PUCR_PULSE_NS = 100;
    localparam int PUCR_PULSE_CYC = (PUCR_PULSE_NS * PUCR_CLK_KHZ + 999999) / 1000000;
    localparam logic [3:0] PUCR_PULSE_LAST = 4'(PUCR_PULSE_CYC - 1);
    // ******************************************************************
    // Carriers
    // ******************************************************************
    typedef struct packed {
        logic [2:0] pp_mode;
        logic [3:0] ecp_fifo_threshold;
        logic pp_irq_pulsed;
        logic [1:0] floppy_on_printer_pins_mux;
        logic midi_en;
        logic high_speed_en;
        logic share_irq;
    } pucr_cfg_type;
    typedef struct packed {
        logic irq;
        logic uart_irq_output_gate;
    } pucr_uart_type;
    typedef struct packed {
        logic o;
        logic oe;
    } pucr_pin_type;
    typedef enum logic {PUCR_ST_IDLE = 1'b0, PUCR_ST_PULSE = 1'b1} pucr_state_type;
endpackage

// *** hdl/pucr_regs.sv ***
// Parallel port and first serial port configuration registers with IRQ routing.
`timescale 1ns/1ps
// How it works
// RULE1: Low three bits select parallel port mode.
// RULE2: Mode register resets to 0x3C.
// RULE3: Bits 6:3 hold FIFO threshold, default 0111.
// RULE4: Type bit one gives low pulse, then release.
// RULE5: Type bit zero follows acknowledge or level.
// RULE6: Type bit ignored in printer and SPP.
// RULE7: Mux field places floppy drives on printer pins.
// RULE8: Serial bit 0 enables MIDI.
// RULE9: Serial bit 1 enables high speed.
// RULE10: Software writes zeros to reserved serial bits.
// RULE11: Serial bit 7 selects IRQ sharing.
// RULE12: Shared mode asserts both pins together.
// RULE13: Unshared pin tristated unless gate bit set.
// RULE14: Shared pins drive OR of gated interrupts.
// RULE15: Software assigns one pin, then sets share.
// RULE16: Same IRQ on both UARTs does no harm.
// RULE17: Only hard reset restores register defaults; soft reset here also clears the event status and enable registers.
// RULE18: Gate bit zero tristates that UART's pin; while shared, that pin stays driven if the other UART's gate is set.
// RULE19: Written values act from next cycle.
module pucr_regs
    import pucr_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic soft_rst,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ack_n,
    input wire logic pp_irq_enable,
    input wire logic [2:0] ecr_mode,
    input wire logic ecp_level_irq,
    input wire logic [3:0] fdc_drive_sel,
    input wire pucr_uart_type uart1,
    input wire pucr_uart_type uart2,
    output pucr_cfg_type cfg,
    output pucr_pin_type pp_irq_pin,
    output pucr_pin_type uart1_irq_pin,
    output pucr_pin_type uart2_irq_pin,
    output logic [3:0] pp_pin_drive_sel,
    output logic [3:0] fdc_pin_drive_sel,
    output logic irq
);
    // ******************************************************************
    // Bus slave
    // ******************************************************************
    logic aw_full_ff;
    logic w_full_ff;
    logic [11:0] awaddr_ff;
    logic [7:0] wbyte_ff;
    logic wstrb0_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic wr_go;
    logic wr_en;
    logic [7:0] pp_mode_ff;
    logic [1:0] pp_mode2_ff;
    logic [7:0] ser1_mode_ff;
    logic [PUCR_EVT_W-1:0] stat_ff;
    logic [PUCR_EVT_W-1:0] en_ff;
    logic [PUCR_EVT_W-1:0] evt;

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == PUCR_PP_MODE_ADDR) || (a == PUCR_PP_MODE2_ADDR) ||
            (a == PUCR_SER1_MODE_ADDR) || (a == PUCR_IRQ_STAT_ADDR) ||
            (a == PUCR_IRQ_EN_ADDR) || (a == PUCR_IRQ_CLR_ADDR);
    endfunction

    assign s_axi_awready = !aw_full_ff && !bvalid_ff;
    assign s_axi_wready = !w_full_ff && !bvalid_ff;
    assign wr_go = aw_full_ff && w_full_ff && !bvalid_ff;
    assign wr_en = wr_go && wstrb0_ff && mapped(awaddr_ff);
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_ff <= 1'b0;
            awaddr_ff <= 12'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_full_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_ff <= 1'b0;
            wbyte_ff <= 8'h00;
            wstrb0_ff <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_ff <= 1'b1;
            wbyte_ff <= s_axi_wdata[7:0];
            wstrb0_ff <= s_axi_wstrb[0];
        end else if (wr_go) begin
            w_full_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= PUCR_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= mapped(awaddr_ff) ? PUCR_RESP_OKAY : PUCR_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= PUCR_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= mapped(s_axi_araddr) ? PUCR_RESP_OKAY : PUCR_RESP_SLVERR;
            case (s_axi_araddr)
                PUCR_PP_MODE_ADDR: rdata_ff <= {24'h0, pp_mode_ff};
                PUCR_PP_MODE2_ADDR: rdata_ff <= {30'h0, pp_mode2_ff};
                PUCR_SER1_MODE_ADDR: rdata_ff <= {24'h0, ser1_mode_ff};
                PUCR_IRQ_STAT_ADDR: rdata_ff <= {29'h0, stat_ff};
                PUCR_IRQ_EN_ADDR: rdata_ff <= {29'h0, en_ff};
                default: rdata_ff <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // ******************************************************************
    // Configuration registers
    // ******************************************************************
    // Soft reset is deliberately not wired here so the port setup survives it.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pp_mode_ff <= PUCR_PP_MODE_RST; // [RULE2] [RULE3] [RULE17]
            pp_mode2_ff <= PUCR_PP_MODE2_RST; // [RULE17]
            ser1_mode_ff <= PUCR_SER1_MODE_RST; // [RULE8] [RULE9] [RULE17]
        end else if (wr_en) begin
            if (awaddr_ff == PUCR_PP_MODE_ADDR) begin
                pp_mode_ff <= wbyte_ff; // [RULE19]
            end
            if (awaddr_ff == PUCR_PP_MODE2_ADDR) begin
                pp_mode2_ff <= wbyte_ff[1:0];
            end
            if (awaddr_ff == PUCR_SER1_MODE_ADDR) begin
                ser1_mode_ff <= wbyte_ff & ~PUCR_SER1_RSVD_MASK; // [RULE10]
            end
        end
    end

    always_comb begin
        cfg.pp_mode = pp_mode_ff[PUCR_MODE_LSB+:3]; // [RULE1]
        cfg.ecp_fifo_threshold = pp_mode_ff[PUCR_THR_LSB+:4]; // [RULE3]
        cfg.pp_irq_pulsed = pp_mode_ff[PUCR_ITYPE_BIT];
        cfg.floppy_on_printer_pins_mux = pp_mode2_ff;
        cfg.midi_en = ser1_mode_ff[PUCR_MIDI_BIT]; // [RULE8]
        cfg.high_speed_en = ser1_mode_ff[PUCR_HS_BIT]; // [RULE9]
        cfg.share_irq = ser1_mode_ff[PUCR_SHARE_BIT]; // [RULE11]
    end

    // ******************************************************************
    // Floppy drive placement
    // ******************************************************************
    logic [3:0] on_pp;

    always_comb begin
        case (cfg.floppy_on_printer_pins_mux)
            PUCR_MUX_DRIVE1: on_pp = 4'h2; // [RULE7]
            PUCR_MUX_DRIVES01: on_pp = 4'h3; // [RULE7]
            default: on_pp = 4'h0;
        endcase
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_drv
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    pp_pin_drive_sel[gi] <= 1'b0;
                    fdc_pin_drive_sel[gi] <= 1'b0;
                end else begin
                    pp_pin_drive_sel[gi] <= on_pp[gi] & fdc_drive_sel[gi]; // [RULE7]
                    fdc_pin_drive_sel[gi] <= ~on_pp[gi] & fdc_drive_sel[gi];
                end
            end
        end
    endgenerate

    // ******************************************************************
    // Parallel port interrupt
    // ******************************************************************
    logic ack_s1_ff;
    logic ack_s2_ff;
    logic pp_basic;
    logic pp_ecp;
    logic level_src;
    logic follow_ack;
    logic gated;
    logic src_prev_ff;
    logic fire;
    logic [3:0] pulse_cnt_ff;
    pucr_state_type state_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ack_s1_ff <= 1'b1;
            ack_s2_ff <= 1'b1;
        end else begin
            ack_s1_ff <= ack_n;
            ack_s2_ff <= ack_s1_ff;
        end
    end

    always_comb begin
        pp_basic = (cfg.pp_mode == PUCR_PM_PRINTER) || (cfg.pp_mode == PUCR_PM_SPP);
        pp_ecp = (cfg.pp_mode == PUCR_PM_ECP) || (cfg.pp_mode == PUCR_PM_ECP_EPP19) ||
            (cfg.pp_mode == PUCR_PM_ECP_EPP17);
        follow_ack = !pp_ecp || (ecr_mode == PUCR_ECR_PRINTER) ||
            (ecr_mode == PUCR_ECR_SPP) || (ecr_mode == PUCR_ECR_EPP); // [RULE5]
        level_src = follow_ack ? ack_s2_ff : ecp_level_irq; // [RULE5]
        gated = follow_ack ? pp_irq_enable : 1'b1;
    end

    // Pulse is started by the source going active, so a long level gives one pulse.
    assign fire = gated && level_src && !src_prev_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_prev_ff <= 1'b0;
        end else begin
            src_prev_ff <= gated && level_src;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || soft_rst) begin
            state_ff <= PUCR_ST_IDLE;
            pulse_cnt_ff <= 4'h0;
        end else begin
            case (state_ff)
                PUCR_ST_IDLE: begin
                    if (fire && cfg.pp_irq_pulsed && !pp_basic) begin
                        state_ff <= PUCR_ST_PULSE; // [RULE4]
                        pulse_cnt_ff <= 4'h0;
                    end
                end
                PUCR_ST_PULSE: begin
                    if (pulse_cnt_ff == PUCR_PULSE_LAST) begin
                        state_ff <= PUCR_ST_IDLE; // [RULE4]
                    end else begin
                        pulse_cnt_ff <= pulse_cnt_ff + 4'h1;
                    end
                end
                default: state_ff <= PUCR_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pp_irq_pin <= '0;
        end else if (cfg.pp_irq_pulsed && !pp_basic) begin
            pp_irq_pin.o <= 1'b0; // [RULE4]
            pp_irq_pin.oe <= (state_ff == PUCR_ST_PULSE);
        end else begin
            pp_irq_pin.o <= level_src; // [RULE5] [RULE6]
            pp_irq_pin.oe <= gated;
        end
    end

    // ******************************************************************
    // Serial port interrupt routing
    // ******************************************************************
    logic u1_act;
    logic u2_act;
    logic shared_prev_ff;

    assign u1_act = uart1.irq && uart1.uart_irq_output_gate;
    assign u2_act = uart2.irq && uart2.uart_irq_output_gate;

    // With the share bit set, both pins register the same value, so a tied IRQ line sees both drivers agree. [RULE16]
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            uart1_irq_pin <= '0;
            uart2_irq_pin <= '0;
        end else if (cfg.share_irq) begin
            uart1_irq_pin.o <= u1_act || u2_act; // [RULE12] [RULE14]
            uart2_irq_pin.o <= u1_act || u2_act; // [RULE12] [RULE14]
            uart1_irq_pin.oe <= uart1.uart_irq_output_gate || uart2.uart_irq_output_gate;
            uart2_irq_pin.oe <= uart1.uart_irq_output_gate || uart2.uart_irq_output_gate;
        end else begin
            uart1_irq_pin.o <= uart1.irq; // [RULE13]
            uart2_irq_pin.o <= uart2.irq; // [RULE13]
            uart1_irq_pin.oe <= uart1.uart_irq_output_gate; // [RULE18]
            uart2_irq_pin.oe <= uart2.uart_irq_output_gate; // [RULE18]
        end
    end

    // ******************************************************************
    // Event status, enable and clear
    // ******************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shared_prev_ff <= 1'b0;
        end else begin
            shared_prev_ff <= cfg.share_irq && (u1_act || u2_act);
        end
    end

    always_comb begin
        evt = '0;
        evt[PUCR_EVT_PULSE] = fire && cfg.pp_irq_pulsed && !pp_basic &&
            (state_ff == PUCR_ST_IDLE);
        evt[PUCR_EVT_SHARED] = cfg.share_irq && (u1_act || u2_act) && !shared_prev_ff;
        evt[PUCR_EVT_RSVD] = wr_en && (awaddr_ff == PUCR_SER1_MODE_ADDR) &&
            ((wbyte_ff & PUCR_SER1_RSVD_MASK) != 8'h00); // [RULE10]
    end

    // A new event in the clearing cycle wins over the clear.
    always_ff @(posedge aclk) begin
        if (!aresetn || soft_rst) begin
            stat_ff <= '0;
        end else if (wr_en && (awaddr_ff == PUCR_IRQ_CLR_ADDR)) begin
            stat_ff <= (stat_ff & ~wbyte_ff[PUCR_EVT_W-1:0]) | evt;
        end else begin
            stat_ff <= stat_ff | evt;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || soft_rst) begin
            en_ff <= '0;
        end else if (wr_en && (awaddr_ff == PUCR_IRQ_EN_ADDR)) begin
            en_ff <= wbyte_ff[PUCR_EVT_W-1:0];
        end
    end

    assign irq = |(stat_ff & en_ff);
endmodule // pucr_regs

// *** bench/pucr_regs_asserts.sv ***
// Concurrent checks on the configuration bank outputs.
`timescale 1ns/1ps
module pucr_regs_asserts
    import pucr_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic soft_rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic pp_irq_enable,
    input wire logic [2:0] ecr_mode,
    input wire logic ecp_level_irq,
    input wire logic [3:0] fdc_drive_sel,
    input wire pucr_uart_type uart1,
    input wire pucr_uart_type uart2,
    input wire pucr_cfg_type cfg,
    input wire pucr_pin_type pp_irq_pin,
    input wire pucr_pin_type uart1_irq_pin,
    input wire pucr_pin_type uart2_irq_pin,
    input wire logic [3:0] pp_pin_drive_sel,
    input wire logic [3:0] fdc_pin_drive_sel
);
    logic [3:0] pmask, ppx, fdx;
    logic g1, g2, sh, anyg, mrg, lvl, pmd, prn, quiet;
    assign pmask = (cfg.floppy_on_printer_pins_mux == PUCR_MUX_DRIVE1) ? 4'h2 :
        (cfg.floppy_on_printer_pins_mux == PUCR_MUX_DRIVES01) ? 4'h3 : 4'h0;
    assign ppx = fdc_drive_sel & pmask;
    assign fdx = fdc_drive_sel & ~pmask;
    assign g1 = uart1.uart_irq_output_gate;
    assign g2 = uart2.uart_irq_output_gate;
    assign sh = cfg.share_irq;
    assign anyg = g1 || g2;
    assign mrg = (g1 && uart1.irq) || (g2 && uart2.irq);
    assign prn = cfg.pp_mode == PUCR_PM_PRINTER;
    assign lvl = !cfg.pp_irq_pulsed && cfg.pp_mode[1] && !(ecr_mode inside {3'h0, 3'h1, 3'h4});
    assign pmd = cfg.pp_irq_pulsed && !(cfg.pp_mode inside {PUCR_PM_PRINTER, PUCR_PM_SPP});
    // A write can only land one edge after both channels were taken.
    assign quiet = soft_rst && !s_axi_awvalid && !s_axi_wvalid && s_axi_awready && s_axi_wready;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_reset_cfg: assert property ($rose(aresetn) |->
        cfg.pp_mode == 3'h4 && cfg.ecp_fifo_threshold == 4'h7 && !sh)
        else $error("configuration not at reset value");
    a_uart1_alone: assert property ($past(aresetn) && !$past(sh) |->
        uart1_irq_pin.oe == $past(g1) && (!$past(g1) || uart1_irq_pin.o == $past(uart1.irq)))
        else $error("uart1 pin wrong while unshared");
    a_uart2_alone: assert property ($past(aresetn) && !$past(sh) |->
        uart2_irq_pin.oe == $past(g2) && (!$past(g2) || uart2_irq_pin.o == $past(uart2.irq)))
        else $error("uart2 pin wrong while unshared");
    a_share_merge: assert property ($past(aresetn) && $past(sh) |->
        uart1_irq_pin.oe == $past(anyg) && uart1_irq_pin.o == $past(mrg) &&
        uart2_irq_pin == uart1_irq_pin)
        else $error("shared uart pins wrong");
    a_mux_pins: assert property ($past(aresetn) |->
        pp_pin_drive_sel == $past(ppx) && fdc_pin_drive_sel == $past(fdx))
        else $error("drive selects on wrong pins");
    a_pulse_len: assert property ($rose(pp_irq_pin.oe) && pmd |->
        (pp_irq_pin.oe && !pp_irq_pin.o) [*4] ##1 !pp_irq_pin.oe)
        else $error("pulse length wrong");
    a_ecp_level: assert property ($past(aresetn) && $past(lvl) |->
        pp_irq_pin.oe && pp_irq_pin.o == $past(ecp_level_irq))
        else $error("level interrupt wrong");
    a_printer_follow: assert property ($past(aresetn) && $past(prn) |->
        pp_irq_pin.oe == $past(pp_irq_enable))
        else $error("printer mode interrupt not following");
    a_soft_keep: assert property (quiet |=> $stable(cfg))
        else $error("soft reset changed configuration");
    c_pulse: cover property ($rose(pp_irq_pin.oe) && pmd);
    c_share: cover property (sh && uart1_irq_pin.oe && uart1_irq_pin.o);
    c_mux: cover property (cfg.floppy_on_printer_pins_mux == PUCR_MUX_DRIVES01);
endmodule // pucr_regs_asserts
bind pucr_regs pucr_regs_asserts i_pucr_regs_asserts (.*);

// *** bench/pucr_host.sv ***
// Register bus master model standing in for host software.
`timescale 1ns/1ps
module pucr_host
    import pucr_pkg::*;
(
    input wire logic aclk,
    output logic [11:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [11:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        fork
            begin
                do @(posedge aclk); while (!s_axi_awready);
                s_axi_awvalid <= 1'b0;
            end
            begin
                do @(posedge aclk); while (!s_axi_wready);
                s_axi_wvalid <= 1'b0;
            end
        join
        while (!s_axi_bvalid) @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask
endmodule // pucr_host

// *** bench/pucr_regs_tb.sv ***
// Self-checking bench for the configuration register bank.
`timescale 1ns/1ps
module pucr_regs_tb import pucr_pkg::*;;
    logic aclk, aresetn, soft_rst, ack_n, pp_irq_enable, ecp_level_irq, irq;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, fdc_drive_sel, pp_pin_drive_sel, fdc_pin_drive_sel, sel, mk;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] ecr_mode;
    logic [2:0] md [7];
    logic [7:0] v;
    logic [33:0] exq[$];
    pucr_uart_type uart1, uart2;
    pucr_cfg_type cfg;
    pucr_pin_type pp_irq_pin, uart1_irq_pin, uart2_irq_pin, e1, e2;
    int n_errors, checks_done, cyc, cnt;
    pucr_regs i_pucr_regs (.*);
    pucr_host i_pucr_host (.*);
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    task automatic check(input logic [33:0] got, input logic [33:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("Checks done %0d, errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    function automatic logic [1:0] pn(input pucr_pin_type p);
        return {p.oe, p.o & p.oe};
    endfunction
    task automatic w(input logic [11:0] a, input logic [7:0] d, input logic [1:0] rs);
        exq.push_back({rs, 32'h0});
        i_pucr_host.wr(a, {24'h0, d});
    endtask
    task automatic r(input logic [11:0] a, input logic [7:0] d, input logic [1:0] rs);
        exq.push_back({rs, 24'h0, d});
        i_pucr_host.rd(a);
    endtask
    // The oldest noted result is matched against each bus answer.
    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready)
            check({s_axi_bresp, 32'h0}, exq.pop_front());
        if (s_axi_rvalid && s_axi_rready)
            check({s_axi_rresp, s_axi_rdata}, exq.pop_front());
    end
    always @(posedge aclk) begin
        {ecp_level_irq, ecr_mode} <= 4'($urandom);
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            end_of_test();
        end
    end
    initial begin
        {aresetn, soft_rst, fdc_drive_sel, uart1, uart2} = '0;
        {ack_n, pp_irq_enable} = 2'h3;
        void'($urandom(32'h924D28EF));
        md = '{PUCR_PM_PRINTER, PUCR_PM_SPP, PUCR_PM_EPP19, PUCR_PM_EPP17, PUCR_PM_ECP,
            PUCR_PM_ECP_EPP19, PUCR_PM_ECP_EPP17};
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        r(PUCR_PP_MODE_ADDR, 8'h3C, PUCR_RESP_OKAY);
        r(PUCR_PP_MODE2_ADDR, 8'h00, PUCR_RESP_OKAY);
        r(PUCR_SER1_MODE_ADDR, 8'h00, PUCR_RESP_OKAY);
        w(12'h100, 8'hFF, PUCR_RESP_SLVERR);
        r(12'h100, 8'h00, PUCR_RESP_SLVERR);
        w(PUCR_IRQ_CLR_ADDR, 8'h07, PUCR_RESP_OKAY);
        w(PUCR_SER1_MODE_ADDR, 8'h03, PUCR_RESP_OKAY);
        r(PUCR_SER1_MODE_ADDR, 8'h03, PUCR_RESP_OKAY);
        check({cfg.midi_en, cfg.high_speed_en}, 2'h3);
        w(PUCR_SER1_MODE_ADDR, 8'h7C, PUCR_RESP_OKAY);
        r(PUCR_SER1_MODE_ADDR, 8'h00, PUCR_RESP_OKAY);
        r(PUCR_IRQ_STAT_ADDR, 8'h04, PUCR_RESP_OKAY);
        check(irq, 1'b0);
        w(PUCR_IRQ_EN_ADDR, 8'h04, PUCR_RESP_OKAY);
        check(irq, 1'b1);
        w(PUCR_IRQ_CLR_ADDR, 8'h04, PUCR_RESP_OKAY);
        check(irq, 1'b0);
        r(PUCR_IRQ_CLR_ADDR, 8'h00, PUCR_RESP_OKAY);
        for (int i = 0; i < 7; i++) begin
            pp_irq_enable <= 1'($urandom);
            v = {1'($urandom), 4'($urandom), md[i]};
            w(PUCR_PP_MODE_ADDR, v, PUCR_RESP_OKAY);
            r(PUCR_PP_MODE_ADDR, v, PUCR_RESP_OKAY);
            check(cfg.pp_mode, md[i]);
        end
        pp_irq_enable <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            w(PUCR_PP_MODE2_ADDR, 8'(m), PUCR_RESP_OKAY);
            sel = 4'($urandom);
            fdc_drive_sel <= sel;
            mk = (m == 1) ? 4'h2 : (m == 2) ? 4'h3 : 4'h0;
            repeat (2) @(posedge aclk);
            check(pp_pin_drive_sel, sel & mk);
            check(fdc_pin_drive_sel, sel & ~mk);
        end
        // The share bit is written first in each block of 16, then every gate and request combination is driven under it.
        for (int j = 0; j < 32; j++) begin
            if (j[3:0] == 4'h0)
                w(PUCR_SER1_MODE_ADDR, {j[4], 7'h0}, PUCR_RESP_OKAY);
            uart1 <= j[3:2];
            uart2 <= j[1:0];
            e1 = {j[3] & j[2], j[2]};
            e2 = {j[1] & j[0], j[0]};
            e1 = j[4] ? {e1.o | e2.o, e1.oe | e2.oe} : e1;
            e2 = j[4] ? e1 : e2;
            repeat (2) @(posedge aclk);
            check(pn(uart1_irq_pin), pn(e1));
            check(pn(uart2_irq_pin), pn(e2));
        end
        v = {1'b1, 4'h7, PUCR_PM_EPP19};
        w(PUCR_PP_MODE_ADDR, v, PUCR_RESP_OKAY);
        repeat (10) @(posedge aclk);
        w(PUCR_IRQ_CLR_ADDR, 8'h07, PUCR_RESP_OKAY);
        cnt = 0;
        for (int i = 0; i < 24; i++) begin
            @(posedge aclk);
            ack_n <= (i > 8);
            cnt += 32'(pp_irq_pin.oe && !pp_irq_pin.o);
        end
        check(cnt, 4);
        r(PUCR_IRQ_STAT_ADDR, 8'h01, PUCR_RESP_OKAY);
        soft_rst <= 1'b1;
        @(posedge aclk);
        soft_rst <= 1'b0;
        r(PUCR_PP_MODE_ADDR, v, PUCR_RESP_OKAY);
        end_of_test();
    end
endmodule // pucr_regs_tb
